// ==== rtl/emd_mac_status.sv ====
// Transmit/receive DMA control and status registers of a 10/100 MAC, AXI4-Lite slave.
// Assumes the datapath runs on aclk and pulses its events for one cycle;
// the MDIO, collision and transmit clock pins are asynchronous and synchronised here.
`timescale 1ns/100ps
module emd_mac_status (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mdio_pin,
   input wire logic collision_pin,
   input wire logic phy_tx_clk,
   input wire logic mgmt_busy,
   input wire logic mgmt_done,
   input wire logic [2:0] tx_fifo_words,
   input wire logic tx_frame_done,
   input wire logic tx_retry_limit,
   input wire logic tx_dma_late,
   input wire logic rx_frame_stored,
   input wire logic rx_next_buffer,
   input wire logic rx_buffer_owned,
   input wire logic rx_dma_fail,
   output logic retry_test,
   output logic rmii_select,
   output logic tx_start,
   output logic [31:0] tx_fetch_addr,
   output logic [10:0] tx_frame_len,
   output logic tx_append_crc,
   output logic tx_oversize,
   output logic tx_short_frame,
   output logic tx_force_bad_crc,
   output logic [31:0] rx_queue_ptr,
   output logic irq_pending
);
   logic aw_held, w_held, wr_go, rd_go;
   logic [7:0] aw_addr;
   logic [31:0] w_data, w_mask, w_val;
   logic [2:0] pin_sync;
   logic mdio_level, col_level, txclk_level, txclk_prev, txclk_rise;
   logic [31:0] cfg;
   logic [31:0] pend_addr, act_addr, q_addr;
   logic [10:0] act_len, q_len;
   logic act_valid, act_no_crc, act_started, q_valid, q_no_crc;
   logic buffer_not_queued, not_queued_prev, tar_wr, tcr_wr, len_wr, tx_overrun_evt;
   logic [6:0] tsr_sticky;
   logic [2:0] rsr_sticky;
   logic [7:0] isr, imr, irq_evt;

   // Byte-lane mask built from the write strobes.
   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   // Register offsets that answer OKAY; anything else gets SLVERR.
   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         emd_pkg::OFS_CFG, emd_pkg::OFS_SR, emd_pkg::OFS_TAR, emd_pkg::OFS_TCR,
         emd_pkg::OFS_TSR, emd_pkg::OFS_RBQP, emd_pkg::OFS_RSR, emd_pkg::OFS_ISR,
         emd_pkg::OFS_IER, emd_pkg::OFS_IDR, emd_pkg::OFS_IMR: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // Pins from the PHY side pass two flip-flops before anything reads them.
   emd_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({phy_tx_clk, collision_pin, mdio_pin}),
      .sync_out(pin_sync)
   );
   assign mdio_level = pin_sync[0];
   assign col_level = pin_sync[1];
   assign txclk_level = pin_sync[2];

   // Rising edges of the link clock pace the start of a frame.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         txclk_prev <= 1'b0;
      else
         txclk_prev <= txclk_level;
   end
   assign txclk_rise = txclk_level & ~txclk_prev;

   // Write channel: address and data are taken in either order, one write at a time.
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   assign wr_go = aw_held & w_held & ~s_axi_bvalid;
   assign w_mask = strb_mask(s_axi_wstrb);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= emd_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata & w_mask;
         end
         if (wr_go)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_addr) ? emd_pkg::RESP_OKAY : emd_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // Unwritten lanes of a read/write register are zeroed; partial writes are not merged.
   assign w_val = w_data;

   // Configuration: retry test and reduced interface select.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg <= 32'h0000_0000;
      else if (wr_go && aw_addr == emd_pkg::OFS_CFG)
         cfg <= w_val;
   end
   assign retry_test = cfg[emd_pkg::CFG_RETRY_TEST];
   assign rmii_select = cfg[emd_pkg::CFG_RMII];

   // Transmit queue: one active frame plus one queued behind it.
   assign buffer_not_queued = ~(act_valid & q_valid);
   assign tar_wr = wr_go && aw_addr == emd_pkg::OFS_TAR;
   assign tcr_wr = wr_go && aw_addr == emd_pkg::OFS_TCR;
   assign len_wr = tcr_wr && buffer_not_queued && w_val[emd_pkg::LEN_W-1:0] != '0;
   assign tx_overrun_evt = (tar_wr | tcr_wr) & ~buffer_not_queued;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pend_addr <= 32'h0000_0000;
         act_addr <= 32'h0000_0000;
         q_addr <= 32'h0000_0000;
         act_len <= '0;
         q_len <= '0;
         act_no_crc <= 1'b0;
         q_no_crc <= 1'b0;
         act_valid <= 1'b0;
         q_valid <= 1'b0;
      end
      else
      begin
         if (tar_wr && buffer_not_queued)
            pend_addr <= w_val;
         // A finished frame hands over to the queued one.
         if (tx_frame_done && act_valid)
         begin
            if (q_valid)
            begin
               act_addr <= q_addr;
               act_len <= q_len;
               act_no_crc <= q_no_crc;
               q_valid <= 1'b0;
            end
            else
               act_valid <= 1'b0;
         end
         if (len_wr)
         begin
            if (!act_valid || (tx_frame_done && !q_valid))
            begin
               act_valid <= 1'b1;
               act_addr <= pend_addr;
               act_len <= w_val[emd_pkg::LEN_W-1:0];
               act_no_crc <= w_val[emd_pkg::TCR_NO_CRC];
            end
            else
            begin
               q_valid <= 1'b1;
               q_addr <= pend_addr;
               q_len <= w_val[emd_pkg::LEN_W-1:0];
               q_no_crc <= w_val[emd_pkg::TCR_NO_CRC];
            end
         end
      end
   end

   // A frame starts on a link clock edge once two words are buffered.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         act_started <= 1'b0;
         tx_start <= 1'b0;
      end
      else
      begin
         tx_start <= 1'b0;
         if (tx_frame_done)
            act_started <= 1'b0;
         else if (act_valid && !act_started && tx_fifo_words >= emd_pkg::START_WORDS
                  && txclk_rise)
         begin
            act_started <= 1'b1;
            tx_start <= 1'b1;
         end
      end
   end
   assign tx_fetch_addr = act_addr;
   assign tx_frame_len = act_len;
   assign tx_append_crc = ~act_no_crc;
   assign tx_short_frame = act_no_crc && act_len < emd_pkg::MIN_FRAME_LEN;
   // Oversize frames are only flagged; the length is never clipped.
   assign tx_oversize = act_len > (act_no_crc ? emd_pkg::MAX_LEN_NO_CRC
                                              : emd_pkg::MAX_LEN_CRC);

   // Bad CRC is forced for the rest of the frame that ran dry.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tx_force_bad_crc <= 1'b0;
      else if (tx_dma_late)
         tx_force_bad_crc <= 1'b1;
      else if (tx_frame_done)
         tx_force_bad_crc <= 1'b0;
   end

   // Transmit sticky flags: a set in the same cycle as a write-one clear wins.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tsr_sticky <= 7'h00;
      else
      begin
         tsr_sticky <= (tsr_sticky & ~((wr_go && aw_addr == emd_pkg::OFS_TSR) ? w_val[6:0]
                                                                              : 7'h00))
                       | {tx_dma_late, tx_frame_done, 2'b00, tx_retry_limit, col_level,
                          tx_overrun_evt};
      end
   end

   // Receive queue pointer: word aligned, steps past each used buffer.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_queue_ptr <= 32'h0000_0000;
      else if (wr_go && aw_addr == emd_pkg::OFS_RBQP)
         rx_queue_ptr <= {w_val[31:2], 2'b00};
      else if (rx_next_buffer && !rx_dma_fail)
         rx_queue_ptr <= rx_queue_ptr + emd_pkg::RX_DESC_STEP;
   end

   // Receive sticky flags, cleared by writing one.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rsr_sticky <= 3'h0;
      else
      begin
         rsr_sticky <= (rsr_sticky & ~((wr_go && aw_addr == emd_pkg::OFS_RSR) ? w_val[2:0]
                                                                              : 3'h0))
                       | {rx_dma_fail, rx_frame_stored, rx_buffer_owned};
      end
   end

   // Interrupt events; slot-empty fires when the queue opens up again.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         not_queued_prev <= 1'b1;
      else
         not_queued_prev <= buffer_not_queued;
   end
   assign irq_evt = {tx_frame_done, buffer_not_queued & ~not_queued_prev, tx_retry_limit,
                     tx_dma_late, tx_overrun_evt, rx_buffer_owned, rx_frame_stored, mgmt_done};

   // Interrupt status clears on read, but an event in the read cycle survives it.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         isr <= 8'h00;
      else if (rd_go && s_axi_araddr[7:2] == emd_pkg::OFS_ISR[7:2])
         isr <= irq_evt;
      else
         isr <= isr | irq_evt;
   end

   // Mask: a one disables the source; enable and disable writes act per bit.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         imr <= emd_pkg::IMR_RESET;
      else if (wr_go && aw_addr == emd_pkg::OFS_IER)
         imr <= imr & ~w_val[7:0];
      else if (wr_go && aw_addr == emd_pkg::OFS_IDR)
         imr <= imr | w_val[7:0];
   end
   assign irq_pending = |(isr & ~imr);

   // Read channel: one read at a time, data registered one cycle after the address.
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_go = s_axi_arvalid & s_axi_arready;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= emd_pkg::RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= is_mapped({s_axi_araddr[7:2], 2'b00}) ? emd_pkg::RESP_OKAY
                                                              : emd_pkg::RESP_SLVERR;
         case ({s_axi_araddr[7:2], 2'b00})
            emd_pkg::OFS_CFG: s_axi_rdata <= cfg;
            emd_pkg::OFS_SR: s_axi_rdata <= {29'h0, mgmt_busy, mdio_level, 1'b0};
            emd_pkg::OFS_TAR: s_axi_rdata <= act_valid ? act_addr : pend_addr;
            emd_pkg::OFS_TCR: s_axi_rdata <= {16'h0, act_no_crc, 4'h0, act_len};
            emd_pkg::OFS_TSR: s_axi_rdata <= {25'h0, tsr_sticky[6:5], buffer_not_queued,
                                              ~act_valid, tsr_sticky[2:0]};
            emd_pkg::OFS_RBQP: s_axi_rdata <= rx_queue_ptr;
            emd_pkg::OFS_RSR: s_axi_rdata <= {29'h0, rsr_sticky};
            emd_pkg::OFS_ISR: s_axi_rdata <= {24'h0, isr};
            emd_pkg::OFS_IMR: s_axi_rdata <= {24'h0, imr};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_cfg_outputs: assert property (wr_go && aw_addr == emd_pkg::OFS_CFG |=>
      retry_test == $past(w_val[emd_pkg::CFG_RETRY_TEST]) &&
      rmii_select == $past(w_val[emd_pkg::CFG_RMII]))
      else $error("cfg bits not applied");
   a_overrun_full: assert property ((tar_wr || tcr_wr) && !buffer_not_queued |=>
      tsr_sticky[emd_pkg::TSR_OVERRUN])
      else $error("transmit overrun not flagged");
   a_start_two_words: assert property (tx_start |->
      $past(tx_fifo_words) >= emd_pkg::START_WORDS && act_valid)
      else $error("frame started early");
   a_idle_cleared: assert property (len_wr |=> act_valid)
      else $error("length write left transmitter idle");
   a_len_stable: assert property (act_valid && !tx_frame_done && !len_wr |=>
      $stable(act_len))
      else $error("transmit length changed mid frame");
   a_isr_keep_evt: assert property (irq_evt[emd_pkg::IRQ_TX_COMPLETE] |=>
      isr[emd_pkg::IRQ_TX_COMPLETE])
      else $error("event lost on status read");
   a_comp_sticky: assert property (tsr_sticky[emd_pkg::TSR_COMP] &&
      !(wr_go && aw_addr == emd_pkg::OFS_TSR) |=> tsr_sticky[emd_pkg::TSR_COMP])
      else $error("complete flag dropped");
   a_rxptr_aligned: assert property (rx_queue_ptr[1:0] == 2'b00)
      else $error("receive pointer unaligned");
   // A disable write must leave every written source masked off.
   a_idr_masks: assert property (wr_go && aw_addr == emd_pkg::OFS_IDR |=>
      (imr & $past(w_val[7:0])) == $past(w_val[7:0]))
      else $error("disable write left source enabled");
   a_no_buffer_set: assert property (rx_buffer_owned |=>
      rsr_sticky[emd_pkg::RSR_NO_BUFFER])
      else $error("buffer not available missed");

   c_two_queued: cover property (act_valid && q_valid);
   c_tx_start: cover property (tx_start);
   c_isr_read_evt: cover property (rd_go && s_axi_araddr == emd_pkg::OFS_ISR && |irq_evt);
   c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == emd_pkg::RESP_SLVERR);
endmodule

// ==== rtl/emd_pkg.sv ====
// Constants, register map and field layout of the MAC transmit/receive status block.
// Assumes a 32-bit AXI4-Lite register bus and a 25 MHz system clock.
package emd_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_SR = 8'h08;
   localparam logic [7:0] OFS_TAR = 8'h0C;
   localparam logic [7:0] OFS_TCR = 8'h10;
   localparam logic [7:0] OFS_TSR = 8'h14;
   localparam logic [7:0] OFS_RBQP = 8'h18;
   localparam logic [7:0] OFS_RSR = 8'h20;
   localparam logic [7:0] OFS_ISR = 8'h24;
   localparam logic [7:0] OFS_IER = 8'h28;
   localparam logic [7:0] OFS_IDR = 8'h2C;
   localparam logic [7:0] OFS_IMR = 8'h30;
   // Configuration fields.
   localparam int CFG_RETRY_TEST = 12;
   localparam int CFG_RMII = 13;
   // Network status fields.
   localparam int SR_MDIO = 1;
   localparam int SR_MGMT_BUSY = 2;
   // Transmit length control fields.
   localparam int LEN_W = 11;
   localparam int TCR_NO_CRC = 15;
   // Transmit status fields.
   localparam int TSR_OVERRUN = 0;
   localparam int TSR_COL = 1;
   localparam int TSR_RETRY_LIMIT = 2;
   localparam int TSR_IDLE = 3;
   localparam int TSR_NOT_QUEUED = 4;
   localparam int TSR_COMP = 5;
   localparam int TSR_UNDERRUN = 6;
   // Receive status fields.
   localparam int RSR_NO_BUFFER = 0;
   localparam int RSR_RECEIVED = 1;
   localparam int RSR_OVERRUN = 2;
   // Interrupt status fields, management done at bit 0 up to transmit complete at bit 7.
   localparam int IRQ_W = 8;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_RX_COMPLETE = 1;
   localparam int IRQ_RX_NO_BUFFER = 2;
   localparam int IRQ_TX_OVERRUN = 3;
   localparam int IRQ_TX_UNDERRUN = 4;
   localparam int IRQ_RETRY = 5;
   localparam int IRQ_SLOT_EMPTY = 6;
   localparam int IRQ_TX_COMPLETE = 7;
   // Reset values and frame limits.
   localparam logic [IRQ_W-1:0] IMR_RESET = 8'hFF;
   localparam logic [LEN_W-1:0] MAX_LEN_CRC = 11'd1514;
   localparam logic [LEN_W-1:0] MAX_LEN_NO_CRC = 11'd1518;
   localparam logic [LEN_W-1:0] MIN_FRAME_LEN = 11'd64;
   localparam logic [2:0] START_WORDS = 3'h2;
   localparam logic [31:0] RX_DESC_STEP = 32'h0000_0008;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/emd_sync.sv ====
// Two-stage synchroniser for levels arriving from outside the system clock domain.
// Assumes the inputs are levels that stay stable longer than two clock periods.
`timescale 1ns/100ps
module emd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second, so metastability never reaches logic.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// ==== testbench/emd_phy_model.sv ====
// Far side model: the PHY transmit clock and the done pulse of the transmit datapath.
// Assumes aclk at 25 MHz; the link clock stands still while the FIFO is empty.
`timescale 1ns/100ps
module emd_phy_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tx_start,
   input wire logic [2:0] tx_fifo_words,
   output logic phy_tx_clk,
   output logic tx_frame_done
);
   int cnt;
   // A 320 ns link clock with a phase offset, so no link edge lines up with aclk.
   initial
   begin
      phy_tx_clk = 1'b0;
      #7;
      forever
      begin
         #160;
         phy_tx_clk = (tx_fifo_words != 3'h0) ? ~phy_tx_clk : 1'b0;
      end
   end
   // Each started frame is on the wire for 80 cycles before done is pulsed.
   always_ff @(posedge aclk)
   begin
      tx_frame_done <= 1'b0;
      if (!aresetn)
         cnt <= 0;
      else if (tx_start)
         cnt <= 80;
      else if (cnt > 0)
      begin
         cnt <= cnt - 1;
         tx_frame_done <= (cnt == 1);
      end
   end
endmodule

// ==== testbench/emd_mac_status_tb.sv ====
// Self-checking bench for the MAC status block over AXI4-Lite.
// Assumes the far side model and the design package are compiled first.
`timescale 1ns/100ps
module emd_mac_status_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, tx_fetch_addr, rx_queue_ptr, rd_val;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
   logic mdio_pin, collision_pin, phy_tx_clk, mgmt_busy, mgmt_done, tx_frame_done;
   logic tx_retry_limit, tx_dma_late, rx_frame_stored, rx_next_buffer, rx_buffer_owned;
   logic rx_dma_fail, retry_test, rmii_select, tx_start, tx_append_crc, tx_oversize;
   logic tx_short_frame, tx_force_bad_crc, irq_pending;
   logic [2:0] tx_fifo_words;
   logic [10:0] tx_frame_len;
   int err_count, checked, starts;
   emd_mac_status u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mdio_pin, .collision_pin, .phy_tx_clk,
      .mgmt_busy, .mgmt_done, .tx_fifo_words, .tx_frame_done, .tx_retry_limit, .tx_dma_late,
      .rx_frame_stored, .rx_next_buffer, .rx_buffer_owned, .rx_dma_fail, .retry_test,
      .rmii_select, .tx_start, .tx_fetch_addr, .tx_frame_len, .tx_append_crc, .tx_oversize,
      .tx_short_frame, .tx_force_bad_crc, .rx_queue_ptr, .irq_pending);
   emd_phy_model u_phy (.aclk, .aresetn, .tx_start, .tx_fifo_words, .phy_tx_clk,
      .tx_frame_done);
   // The clock runs at 25 MHz.
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // Frame starts stand one cycle, so they are counted at every edge.
   always @(posedge aclk)
   begin
      if (tx_start === 1'b1)
         starts++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Handshakes are sampled one step after each edge, where settled values hold.
   // Ready stays high between calls, so no call lowers what the next one raises.
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         #1;
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid & s_axi_bready;
         rd_resp = s_axi_bresp;
         @(posedge aclk);
         if (aw)
            s_axi_awvalid <= 1'b0;
         if (w)
            s_axi_wvalid <= 1'b0;
      end
      while (!b);
   endtask
   task automatic axr(input logic [7:0] a);
      logic ar, r;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         #1;
         ar = s_axi_arvalid & s_axi_arready;
         r = s_axi_rvalid & s_axi_rready;
         rd_val = s_axi_rdata;
         rd_resp = s_axi_rresp;
         @(posedge aclk);
         if (ar)
            s_axi_arvalid <= 1'b0;
      end
      while (!r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      axr(a);
      chk(rd_val, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Only the watchdog ends a wait that never sees the start.
   task automatic wait_starts(input int k);
      while (starts < k)
         @(posedge aclk);
   endtask
   // A hang is cut short at 10000 cycles, well past the few hundred cycles the tests need.
   initial
   begin
      #400000;
      err_count++;
      complete_run();
   end
   // Main sequence: reset, configuration, two queued frames, events, interrupts.
   initial
   begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_fifo_words} = '0;
      {mdio_pin, collision_pin, mgmt_busy, mgmt_done, tx_retry_limit, tx_dma_late} = '0;
      {rx_frame_stored, rx_next_buffer, rx_buffer_owned, rx_dma_fail} = '0;
      s_axi_wstrb = 4'hF;
      cyc(4);
      aresetn <= 1'b1;
      cyc(2);
      rd(emd_pkg::OFS_TSR, 32'h18);
      rd(emd_pkg::OFS_IMR, 32'hFF);
      axw(emd_pkg::OFS_CFG, 32'h3000);
      chk({30'h0, retry_test, rmii_select}, 32'h3);
      axw(emd_pkg::OFS_CFG, 32'h1000);
      chk({30'h0, retry_test, rmii_select}, 32'h2);
      mdio_pin <= 1'b1;
      mgmt_busy <= 1'b1;
      cyc(4);
      rd(emd_pkg::OFS_SR, 32'h6);
      mdio_pin <= 1'b0;
      cyc(4);
      rd(emd_pkg::OFS_SR, 32'h4);
      axr(8'h1C);
      chk({30'h0, rd_resp}, {30'h0, emd_pkg::RESP_SLVERR});
      axw(8'h3C, 32'h1);
      chk({30'h0, rd_resp}, {30'h0, emd_pkg::RESP_SLVERR});
      axw(emd_pkg::OFS_TAR, 32'h1000_0002);
      axw(emd_pkg::OFS_TCR, 32'h0000_05EB);
      rd(emd_pkg::OFS_TSR, 32'h10);
      tx_fifo_words <= 3'h1;
      cyc(40);
      chk(32'(starts), 32'h0);
      tx_fifo_words <= 3'h2;
      wait_starts(1);
      chk(tx_fetch_addr, 32'h1000_0002);
      chk({21'h0, tx_frame_len}, 32'h5EB);
      chk({29'h0, tx_append_crc, tx_oversize, tx_short_frame}, 32'h6);
      axw(emd_pkg::OFS_TAR, 32'h3000_0000);
      axw(emd_pkg::OFS_TCR, 32'h0000_8028);
      rd(emd_pkg::OFS_TSR, 32'h0);
      axw(emd_pkg::OFS_TAR, 32'h5);
      rd(emd_pkg::OFS_TSR, 32'h1);
      rd(emd_pkg::OFS_TCR, 32'h5EB);
      rd(emd_pkg::OFS_TAR, 32'h1000_0002);
      axw(emd_pkg::OFS_TSR, 32'h1);
      rd(emd_pkg::OFS_TSR, 32'h0);
      wait_starts(2);
      chk(tx_fetch_addr, 32'h3000_0000);
      chk({29'h0, tx_append_crc, tx_oversize, tx_short_frame}, 32'h1);
      rd(emd_pkg::OFS_TSR, 32'h30);
      rd(emd_pkg::OFS_TCR, 32'h8028);
      cyc(90);
      tx_fifo_words <= 3'h0;
      rd(emd_pkg::OFS_TSR, 32'h38);
      collision_pin <= 1'b1;
      {mgmt_done, tx_retry_limit, tx_dma_late, rx_frame_stored, rx_buffer_owned} <= 5'h1F;
      rx_dma_fail <= 1'b1;
      cyc(1);
      {mgmt_done, tx_retry_limit, tx_dma_late, rx_frame_stored, rx_buffer_owned} <= 5'h00;
      rx_dma_fail <= 1'b0;
      cyc(4);
      collision_pin <= 1'b0;
      cyc(4);
      chk({31'h0, tx_force_bad_crc}, 32'h1);
      rd(emd_pkg::OFS_TSR, 32'h7E);
      axw(emd_pkg::OFS_TSR, 32'h67);
      rd(emd_pkg::OFS_TSR, 32'h18);
      rd(emd_pkg::OFS_RSR, 32'h7);
      axw(emd_pkg::OFS_RSR, 32'h7);
      rd(emd_pkg::OFS_RSR, 32'h0);
      axr(emd_pkg::OFS_ISR);
      chk(rd_val, 32'hFF);
      rd(emd_pkg::OFS_ISR, 32'h0);
      axw(emd_pkg::OFS_RBQP, 32'h2003);
      rd(emd_pkg::OFS_RBQP, 32'h2000);
      rx_next_buffer <= 1'b1;
      cyc(1);
      rx_next_buffer <= 1'b0;
      cyc(1);
      rd(emd_pkg::OFS_RBQP, 32'h2008);
      {rx_next_buffer, rx_dma_fail} <= 2'b11;
      cyc(1);
      {rx_next_buffer, rx_dma_fail} <= 2'b00;
      cyc(1);
      chk(rx_queue_ptr, 32'h2008);
      axw(emd_pkg::OFS_IER, 32'h1);
      rd(emd_pkg::OFS_IMR, 32'hFE);
      mgmt_done <= 1'b1;
      cyc(1);
      mgmt_done <= 1'b0;
      cyc(2);
      chk({31'h0, irq_pending}, 32'h1);
      axw(emd_pkg::OFS_IDR, 32'h1);
      chk({31'h0, irq_pending}, 32'h0);
      complete_run();
   end
endmodule
